// ### src/occg_params.svh
`ifndef OCCG_PARAMS_SVH
`define OCCG_PARAMS_SVH

// Register indices and byte addresses: each register takes one aligned
// word, so its byte address is four times its index.
`define OCCG_IDX_GATE_1      16'h300C
`define OCCG_IDX_GATE_2      16'h300D
`define OCCG_IDX_GATE_3      16'h300E
`define OCCG_IDX_GATE_4      16'h300F
`define OCCG_IDX_OSC         16'h303E
`define OCCG_ADDR_GATE_1     18'h0C030
`define OCCG_ADDR_GATE_2     18'h0C034
`define OCCG_ADDR_GATE_3     18'h0C038
`define OCCG_ADDR_GATE_4     18'h0C03C
`define OCCG_ADDR_OSC        18'h0C0F8

// Reset values.
`define OCCG_RST_GATE_1      8'hE7
`define OCCG_RST_GATE_2      8'h3C
`define OCCG_RST_GATE_3      8'h7E
`define OCCG_RST_GATE_4      8'hA7
`define OCCG_RST_OSC         8'h00

// Writable bit masks; reserved bits read zero.
`define OCCG_MASK_GATE_1     8'hE7
`define OCCG_MASK_OSC        8'hB6

// Oscillator register fields.
`define OCCG_OSC_ENABLE      7
`define OCCG_OSC_STOP_KEEP   5
`define OCCG_OSC_OUT_SEL     4
`define OCCG_OSC_RANGE       2
`define OCCG_OSC_HIGH_GAIN   1
`define OCCG_OSC_INIT_DONE   0

// Gate 1 fields.
`define OCCG_G1_FLEX_TWO     7
`define OCCG_G1_FLEX_ONE     6
`define OCCG_G1_FLEX_ZERO    5
`define OCCG_G1_MOD_ONE      2
`define OCCG_G1_MOD_ZERO     1
`define OCCG_G1_RTC          0

// Oscillator start-up time and its cycle count at 100 MHz.
`define OCCG_INIT_TIME_US    20
`define OCCG_CLK_MHZ         100
`define OCCG_INIT_CYCLES     (`OCCG_INIT_TIME_US * `OCCG_CLK_MHZ)

`endif

// ### src/occg_pkg.sv
package occg_pkg;
  typedef enum logic [1:0] {
    OCCG_OSC_OFF,
    OCCG_OSC_STARTING,
    OCCG_OSC_RUNNING
  } occg_osc_state_type;

  typedef logic [7:0]  occg_byte_type;
  typedef logic [11:0] occg_count_type;
  typedef logic [17:0] occg_addr_type;
endpackage

// ### src/occg_clock_gate.sv
module occg_clock_gate (
  // Clock and enable.
  input  wire logic clk_i,
  input  wire logic enable_i,
  // Gated clock.
  output logic      gclk_o
);
  import occg_pkg::*;

  typedef struct packed {
    logic en;
  } occg_gate_state_type;

  occg_gate_state_type state_reg;
  occg_gate_state_type state_next;

  always_comb begin
    state_next    = state_reg;
    state_next.en = enable_i;
  end

  // Latch-free gate: the enable is taken on the falling edge while the clock
  // is low, so a change never cuts a high phase short.
  always_ff @(negedge clk_i) begin
    state_reg <= state_next; // [RL17]
  end

  assign gclk_o = clk_i & state_reg.en; // [RL17]
endmodule

// ### src/occg_top.sv
// Summary of operation
// RL1: Stop-keep bit decides oscillator survival in stop.
// RL2: Output select: external pin or crystal.
// RL3: Range bit selects low or high band.
// RL4: Gain bit selects low or high gain.
// RL5: Init-done reads zero until startup finished.
// RL6: Reserved bits always read zero.
// RL7: Gate 1 bits 7..5 gate flex timers.
// RL8: Gate 1 bits 2..1 gate modulo timers.
// RL9: Gate 1 bit 0 gates real-time counter.
// RL10: Gate 1 at 300C, resets E7h.
// RL11: Gate 2 at 300D, resets 3Ch.
// RL12: Gate 3 at 300E, resets 7Eh.
// RL13: Gate 4 at 300F, resets A7h.
// RL14: Software disables peripheral before gating it.
// RL15: Software reinitializes peripheral after ungating.
// RL16: Enable bit turns on the oscillator module.
// RL17: Clock gates switch without glitches.
// RL18: Init-done clears when oscillator disabled.
//
// Implementation choice: register access over APB.
`include "occg_params.svh"

module occg_top #(
  parameter int INIT_CYCLES = `OCCG_INIT_CYCLES
) (
  // Clock and reset.
  input  wire logic                    ref_clk_i,
  input  wire logic                    rst_i,
  // APB slave.
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire occg_pkg::occg_addr_type paddr_i,
  input  wire logic [31:0]             pwdata_i,
  output logic [31:0]                  prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  // Chip mode and clock sources.
  input  wire logic                    stop_mode_i,
  input  wire logic                    clkgen_active_i,
  input  wire logic                    ext_clock_pin_i,
  input  wire logic                    crystal_clock_i,
  // Oscillator control.
  output logic                         osc_run_o,
  output logic                         osc_high_range_o,
  output logic                         osc_high_gain_o,
  output logic                         osc_clock_o,
  output logic                         ext_reference_clock_out_o,
  // Gated bus clocks and the gate 2 to 4 register values.
  output logic                         flex_timer_two_clk_o,
  output logic                         flex_timer_one_clk_o,
  output logic                         flex_timer_zero_clk_o,
  output logic                         modulo_timer_one_clk_o,
  output logic                         modulo_timer_zero_clk_o,
  output logic                         rtc_clk_o,
  output logic [7:0]                   periph_clock_gate_2_o,
  output logic [7:0]                   periph_clock_gate_3_o,
  output logic [7:0]                   periph_clock_gate_4_o
);
  import occg_pkg::*;

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    occg_byte_type      gate_1;
    occg_byte_type      gate_2;
    occg_byte_type      gate_3;
    occg_byte_type      gate_4;
    occg_byte_type      osc_ctrl;
    occg_osc_state_type osc_state;
    occg_count_type     init_cnt;
    logic [31:0]        rdata;
  } occg_state_type;

  localparam occg_count_type INIT_LAST = occg_count_type'(INIT_CYCLES - 1);

  occg_state_type state_reg;
  occg_state_type state_next;

  logic           wr_en;
  logic           rd_en;
  logic           addr_hit;
  logic           osc_live;
  occg_byte_type  wbyte;
  occg_byte_type  osc_view;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign wbyte = pwdata_i[7:0];
  always_comb begin
    unique case (paddr_i)
      `OCCG_ADDR_GATE_1,
      `OCCG_ADDR_GATE_2,
      `OCCG_ADDR_GATE_3,
      `OCCG_ADDR_GATE_4,
      `OCCG_ADDR_OSC:    addr_hit = 1'b1;
      default:           addr_hit = 1'b0;
    endcase
  end
  assign wr_en = psel_i & penable_i & pwrite_i & addr_hit;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;

  // The oscillator keeps running in stop only when software set the stop-keep
  // bit; clkgen_active_i has no effect, as the enable bit is already required.
  assign osc_live = state_reg.osc_ctrl[`OCCG_OSC_ENABLE] &
                    (~stop_mode_i |
                     (state_reg.osc_ctrl[`OCCG_OSC_STOP_KEEP] &
                      (state_reg.osc_ctrl[`OCCG_OSC_ENABLE] |
                       clkgen_active_i))); // [RL1] [RL16]

  always_comb begin
    osc_view = state_reg.osc_ctrl & `OCCG_MASK_OSC; // [RL6]
    osc_view[`OCCG_OSC_INIT_DONE] =
      (state_reg.osc_state == OCCG_OSC_RUNNING); // [RL5]
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    if (wr_en) begin
      unique case (paddr_i)
        `OCCG_ADDR_GATE_1: state_next.gate_1 = wbyte & `OCCG_MASK_GATE_1;
        `OCCG_ADDR_GATE_2: state_next.gate_2 = wbyte; // [RL11]
        `OCCG_ADDR_GATE_3: state_next.gate_3 = wbyte; // [RL12]
        `OCCG_ADDR_GATE_4: state_next.gate_4 = wbyte; // [RL13]
        `OCCG_ADDR_OSC:    state_next.osc_ctrl = wbyte & `OCCG_MASK_OSC;
        default:           state_next.osc_ctrl = state_reg.osc_ctrl;
      endcase
    end
    // Read data is captured in setup so it comes from a flip-flop.
    if (rd_en) begin
      state_next.rdata = 32'h0000_0000;
      unique case (paddr_i)
        `OCCG_ADDR_GATE_1: state_next.rdata[7:0] = state_reg.gate_1; // [RL10]
        `OCCG_ADDR_GATE_2: state_next.rdata[7:0] = state_reg.gate_2;
        `OCCG_ADDR_GATE_3: state_next.rdata[7:0] = state_reg.gate_3;
        `OCCG_ADDR_GATE_4: state_next.rdata[7:0] = state_reg.gate_4;
        `OCCG_ADDR_OSC:    state_next.rdata[7:0] = osc_view;
        default:           state_next.rdata = 32'h0000_0000;
      endcase
    end
    // Start-up sequencing of the oscillator.
    unique case (state_reg.osc_state)
      OCCG_OSC_OFF: begin
        state_next.init_cnt = '0;
        if (osc_live) begin
          state_next.osc_state = OCCG_OSC_STARTING;
        end
      end
      OCCG_OSC_STARTING: begin
        if (!osc_live) begin
          state_next.osc_state = OCCG_OSC_OFF; // [RL18]
        end else if (state_reg.init_cnt == INIT_LAST) begin
          state_next.osc_state = OCCG_OSC_RUNNING; // [RL5]
        end else begin
          state_next.init_cnt = state_reg.init_cnt + 12'h001;
        end
      end
      OCCG_OSC_RUNNING: begin
        if (!osc_live) begin
          state_next.osc_state = OCCG_OSC_OFF; // [RL18]
        end
      end
      default: state_next.osc_state = OCCG_OSC_OFF;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_reg.gate_1    <= `OCCG_RST_GATE_1; // [RL10]
      state_reg.gate_2    <= `OCCG_RST_GATE_2; // [RL11]
      state_reg.gate_3    <= `OCCG_RST_GATE_3; // [RL12]
      state_reg.gate_4    <= `OCCG_RST_GATE_4; // [RL13]
      state_reg.osc_ctrl  <= `OCCG_RST_OSC;
      state_reg.osc_state <= OCCG_OSC_OFF;
      state_reg.init_cnt  <= '0;
      state_reg.rdata     <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign prdata_o  = state_reg.rdata;
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~addr_hit;

  assign osc_run_o        = osc_live; // [RL1] [RL16]
  assign osc_high_range_o = state_reg.osc_ctrl[`OCCG_OSC_RANGE]; // [RL3]
  assign osc_high_gain_o  = state_reg.osc_ctrl[`OCCG_OSC_HIGH_GAIN]; // [RL4]
  // The source mux itself is not glitch-free; software should switch it
  // only with the oscillator disabled.
  assign osc_clock_o = osc_live &
                       (state_reg.osc_ctrl[`OCCG_OSC_OUT_SEL] ?
                        crystal_clock_i : ext_clock_pin_i); // [RL2]
  assign ext_reference_clock_out_o = osc_clock_o; // [RL16]

  assign periph_clock_gate_2_o = state_reg.gate_2;
  assign periph_clock_gate_3_o = state_reg.gate_3;
  assign periph_clock_gate_4_o = state_reg.gate_4;

  // ------------------------------------------------------------------
  // Peripheral bus-clock gates
  // ------------------------------------------------------------------
  occg_clock_gate u_gate_ft2 (
    .clk_i    (ref_clk_i),
    .enable_i (state_reg.gate_1[`OCCG_G1_FLEX_TWO]), // [RL7]
    .gclk_o   (flex_timer_two_clk_o)
  );
  occg_clock_gate u_gate_ft1 (
    .clk_i    (ref_clk_i),
    .enable_i (state_reg.gate_1[`OCCG_G1_FLEX_ONE]), // [RL7]
    .gclk_o   (flex_timer_one_clk_o)
  );
  occg_clock_gate u_gate_ft0 (
    .clk_i    (ref_clk_i),
    .enable_i (state_reg.gate_1[`OCCG_G1_FLEX_ZERO]), // [RL7]
    .gclk_o   (flex_timer_zero_clk_o)
  );
  occg_clock_gate u_gate_mt1 (
    .clk_i    (ref_clk_i),
    .enable_i (state_reg.gate_1[`OCCG_G1_MOD_ONE]), // [RL8]
    .gclk_o   (modulo_timer_one_clk_o)
  );
  occg_clock_gate u_gate_mt0 (
    .clk_i    (ref_clk_i),
    .enable_i (state_reg.gate_1[`OCCG_G1_MOD_ZERO]), // [RL8]
    .gclk_o   (modulo_timer_zero_clk_o)
  );
  occg_clock_gate u_gate_rtc (
    .clk_i    (ref_clk_i),
    .enable_i (state_reg.gate_1[`OCCG_G1_RTC]), // [RL9]
    .gclk_o   (rtc_clk_o)
  );
endmodule

// ### verification/occg_chk.sv
`include "occg_params.svh"

module occg_chk
  import occg_pkg::*;
#(
  parameter int INIT_CYCLES = 4
) (
  // Clock, reset and bus.
  input wire logic          ref_clk_i,
  input wire logic          rst_i,
  input wire logic          psel_i,
  input wire logic          penable_i,
  input wire logic          pwrite_i,
  input wire occg_addr_type paddr_i,
  input wire logic [31:0]   pwdata_i,
  input wire logic [31:0]   prdata_o,
  input wire logic          pslverr_o,
  // Oscillator and gates.
  input wire logic          stop_mode_i,
  input wire logic          osc_run_o,
  input wire logic          osc_clock_o,
  input wire logic          ext_reference_clock_out_o,
  input wire logic          flex_timer_two_clk_o,
  input wire logic          flex_timer_one_clk_o,
  input wire logic          flex_timer_zero_clk_o,
  input wire logic          modulo_timer_one_clk_o,
  input wire logic          modulo_timer_zero_clk_o,
  input wire logic          rtc_clk_o
);
  logic [5:0]  g1_exp_reg;
  logic [15:0] run_cnt_reg;
  logic [5:0]  gates;
  logic        rd_osc;
  logic        mapped;

  assign gates  = {flex_timer_two_clk_o, flex_timer_one_clk_o,
                   flex_timer_zero_clk_o, modulo_timer_one_clk_o,
                   modulo_timer_zero_clk_o, rtc_clk_o};
  assign rd_osc = psel_i && !penable_i && !pwrite_i
                  && paddr_i == `OCCG_ADDR_OSC;
  assign mapped = paddr_i inside {`OCCG_ADDR_GATE_1, `OCCG_ADDR_GATE_2,
                  `OCCG_ADDR_GATE_3, `OCCG_ADDR_GATE_4, `OCCG_ADDR_OSC};

  // Expected gate enables and the length of the current oscillator run.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      g1_exp_reg  <= 6'h3F;
      run_cnt_reg <= 16'h0000;
    end else begin
      if (psel_i && penable_i && pwrite_i && paddr_i == `OCCG_ADDR_GATE_1)
        g1_exp_reg <= {pwdata_i[7:5], pwdata_i[2:0]};
      run_cnt_reg <= osc_run_o ? run_cnt_reg + 16'h0001 : 16'h0000;
    end
  end

  // A gated clock is low just before each rising edge of the bus clock.
  gate_glitch_a: assert property (@(posedge ref_clk_i)
    disable iff (rst_i) gates == 6'h00)
    else $error("gated clock high in low phase");
  flex_gate_a: assert property (@(negedge ref_clk_i)
    disable iff (rst_i)
    $stable(g1_exp_reg) |-> gates[5:3] == g1_exp_reg[5:3])
    else $error("flex timer clock gate wrong");
  timer_gate_a: assert property (@(negedge ref_clk_i)
    disable iff (rst_i)
    $stable(g1_exp_reg) |-> gates[2:0] == g1_exp_reg[2:0])
    else $error("timer or counter clock gate wrong");
  osc_off_a: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    !osc_run_o |-> !osc_clock_o && !ext_reference_clock_out_o)
    else $error("oscillator clock while disabled");
  stop_hold_a: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    stop_mode_i && $past(stop_mode_i) && !$past(psel_i)
    |-> $stable(osc_run_o))
    else $error("oscillator state changed in stop");
  init_low_a: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    rd_osc && run_cnt_reg < INIT_CYCLES |=> !prdata_o[0])
    else $error("init done set too early");
  init_high_a: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    rd_osc && run_cnt_reg > INIT_CYCLES + 1 |=> prdata_o[0])
    else $error("init done not set");
  resv_zero_a: assert property (@(posedge ref_clk_i)
    disable iff (rst_i)
    rd_osc |=> prdata_o[31:8] == 24'h0 && !prdata_o[6] && !prdata_o[3])
    else $error("reserved bits not zero");
  slv_err_a: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    pslverr_o == (psel_i && penable_i && !mapped))
    else $error("error response wrong");
endmodule

bind occg_top occg_chk #(.INIT_CYCLES(INIT_CYCLES)) u_chk (.*);

// ### verification/test_osc_ctrl_and_periph_clock_gating.sv
`include "occg_params.svh"

module test_osc_ctrl_and_periph_clock_gating;
  timeunit 1ns;
  timeprecision 1ns;
  import occg_pkg::*;
  // Short start-up count keeps the run brief.
  localparam int IC = 4;
  logic          ref_clk_i = 1'h0;
  logic          rst_i = 1'h1;
  logic          psel_i = 1'h0;
  logic          penable_i = 1'h0;
  logic          pwrite_i = 1'h0;
  occg_addr_type paddr_i = '0;
  logic [31:0]   pwdata_i = '0;
  logic          stop_mode_i = 1'h0;
  logic          clkgen_active_i = 1'h0;
  logic          ext_clock_pin_i = 1'h0;
  logic          crystal_clock_i = 1'h1;
  logic [31:0]   prdata_o;
  logic          pready_o, pslverr_o, osc_run_o, osc_high_range_o;
  logic          osc_high_gain_o, osc_clock_o, ext_reference_clock_out_o;
  logic          flex_timer_two_clk_o, flex_timer_one_clk_o;
  logic          flex_timer_zero_clk_o, modulo_timer_one_clk_o;
  logic          modulo_timer_zero_clk_o, rtc_clk_o;
  logic [7:0]    periph_clock_gate_2_o, periph_clock_gate_3_o;
  logic [7:0]    periph_clock_gate_4_o;
  int            fails = 0;
  int            check_count = 0;

  occg_top #(.INIT_CYCLES(IC)) DUT (.*);

  always #5 ref_clk_i = ~ref_clk_i;

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic xfer(input occg_addr_type a, input logic w,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge ref_clk_i);
    psel_i    <= 1'h1;
    penable_i <= 1'h0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'h1;
    @(posedge ref_clk_i);
    while (pready_o !== 1'h1)
      @(posedge ref_clk_i);
    q = prdata_o;
    e = pslverr_o;
    psel_i    <= 1'h0;
    penable_i <= 1'h0;
  endtask

  task automatic wr(input occg_addr_type a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    xfer(a, 1'h1, d, q, e);
  endtask

  task automatic rd(input occg_addr_type a, input logic [31:0] x);
    logic [31:0] q;
    logic        e;
    xfer(a, 1'h0, 32'h0, q, e);
    cmp(q, x);
  endtask

  // Gated clocks are high just after a rising edge only when enabled.
  task automatic gates(input logic [31:0] x);
    repeat (2) @(posedge ref_clk_i);
    #2;
    cmp({flex_timer_two_clk_o, flex_timer_one_clk_o, flex_timer_zero_clk_o,
         modulo_timer_one_clk_o, modulo_timer_zero_clk_o, rtc_clk_o}, x);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(`OCCG_ADDR_GATE_1, 32'hE7);
    rd(`OCCG_ADDR_GATE_2, 32'h3C);
    rd(`OCCG_ADDR_GATE_3, 32'h7E);
    rd(`OCCG_ADDR_GATE_4, 32'hA7);
    rd(`OCCG_ADDR_OSC, 32'h00);
  endtask

  task automatic t_gates();
    occg_addr_type ga[3];
    ga = '{`OCCG_ADDR_GATE_2, `OCCG_ADDR_GATE_3, `OCCG_ADDR_GATE_4};
    wr(`OCCG_ADDR_GATE_1, 32'hFFFFFFFF);
    rd(`OCCG_ADDR_GATE_1, 32'hE7);
    // Timers here have no function of their own to stop or reload first.
    wr(`OCCG_ADDR_GATE_1, 32'h41);
    gates(32'h11);
    wr(`OCCG_ADDR_GATE_1, 32'hA6);
    gates(32'h2E);
    foreach (ga[i]) begin
      wr(ga[i], 32'h5A);
      rd(ga[i], 32'h5A);
    end
    cmp({periph_clock_gate_2_o, periph_clock_gate_3_o,
         periph_clock_gate_4_o}, 32'h5A5A5A);
  endtask

  task automatic t_unmapped();
    logic [31:0] q;
    logic        e;
    xfer(18'h0C040, 1'h1, 32'hFF, q, e);
    cmp(e, 32'h1);
    xfer(18'h0C040, 1'h0, 32'h0, q, e);
    cmp({q[30:0], e}, 32'h1);
  endtask

  task automatic t_osc();
    clkgen_active_i <= 1'h1;
    wr(`OCCG_ADDR_OSC, 32'hFF);
    rd(`OCCG_ADDR_OSC, 32'hB6);
    cmp({osc_high_range_o, osc_high_gain_o, osc_clock_o},
        32'h7);
    cmp(ext_reference_clock_out_o, 32'h1);
    repeat (IC + 4) @(posedge ref_clk_i);
    rd(`OCCG_ADDR_OSC, 32'hB7);
    wr(`OCCG_ADDR_OSC, 32'h86);
    stop_mode_i <= 1'h1;
    @(negedge ref_clk_i);
    cmp({osc_run_o, osc_clock_o}, 32'h0);
    wr(`OCCG_ADDR_OSC, 32'hA6);
    @(negedge ref_clk_i);
    cmp({osc_run_o, osc_clock_o}, 32'h2);
    stop_mode_i <= 1'h0;
    wr(`OCCG_ADDR_OSC, 32'h00);
    @(negedge ref_clk_i);
    cmp({osc_run_o, ext_reference_clock_out_o}, 32'h0);
    cmp({osc_high_range_o, osc_high_gain_o}, 32'h0);
    rd(`OCCG_ADDR_OSC, 32'h00);
  endtask

  task automatic conclude();
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    t_reset();
    t_gates();
    t_unmapped();
    t_osc();
    conclude();
  end

  initial begin
    repeat (3000) @(posedge ref_clk_i);
    fails++;
    conclude();
  end
endmodule
